// [hw/ppw_page_walker.sv]
/*
  Extended-address page walker: translates 32-bit linear addresses to 36-bit physical
  addresses through a pointer table, directory and table held in system memory, and
  writes back accessed and dirty flags. Assumes a memory port that holds mem_rdata
  valid with mem_ack, and a register master issuing one-cycle strobes.
*/
//
// Contract
// - translate only when paging_on and addr_extension_on are both set
// - physical addresses are 36 bits wide in extended mode
// - 4-KByte and 2-MByte pages mix within one set of tables
// - every entry is 64 bits; directories and tables hold 512 entries
// - pointer table above the directory holds exactly four entries
// - root pointer bits 31:5 locate the pointer table on 32 bytes
// - linear bits 31:30 pick the pointer-table entry
// - linear bits 29:21 index the directory
// - small pages: bits 20:12 index the table, 11:0 are offset
// - large pages skip the table; bits 20:0 are the offset
// - directory bit 7 clear means table, set means 2-MByte page
// - large_page_ext is ignored for page size in extended mode
// - table-pointing bases are the upper 24 bits, 4-KByte aligned
// - large-page base is the upper 15 bits, 2-MByte aligned
// - check pointer-entry present bit; clear means other bits are meaningless
// - accessed and dirty exist only in page-mapping entries
// - bits 9 to 11 ignored; non-present entries ignore bits 1 to 63
// - nonzero reserved bits in directory or table entries raise page_fault_exc
// - nonzero reserved bits in a pointer entry raise protection_fault_exc
// - bases locate a directory, a table or page, a page
// - feature flag bit 6 reports address-extension support
// - set accessed on first access, never clear it
// - set dirty on first write, never clear it
`timescale 1ns/1ps
`include "ppw_page_walker_cfg.svh"

module ppw_page_walker (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  input  wire ppw_pkg::ppw_req_t req,
  input  wire logic             req_valid,
  output logic                  req_ready,
  output logic                  rsp_valid,
  output ppw_pkg::ppw_rsp_t     rsp,
  output logic                  mem_req,
  output logic                  mem_we,
  output logic      [35:0]      mem_addr,
  output logic      [63:0]      mem_wdata,
  input  wire logic             mem_ack,
  input  wire logic [63:0]      mem_rdata
);
  import ppw_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ppw_state_t  state;
  logic [31:0] system_control_0;
  logic [31:0] feature_control_word;
  logic [31:0] translation_root_pointer;
  logic [31:0] lin_q;
  logic        wr_q;
  logic        large_q;
  logic        ext_q;
  logic [31:0] fault_linear;
  ppw_rsp_t    rsp_q;

  logic        paging_on;
  logic        addr_extension_on;
  logic        large_page_ext;
  logic        ext_mode;
  logic        ent_present;
  logic        ent_large;
  logic        ptr_rsvd;
  logic        dir_rsvd;
  logic        tbl_rsvd;
  logic        need_upd;
  logic [63:0] upd_data;
  logic [35:0] ptr_addr;
  logic [35:0] dir_addr;
  logic [35:0] tbl_addr;
  logic [35:0] small_phys;
  logic [35:0] large_phys;
  logic [31:0] id_features;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // decode of control bits and of the fetched entry
  // ----------------------------------------------------------------
  assign paging_on         = system_control_0[`PPW_BIT_PAGING_ON];
  assign addr_extension_on = feature_control_word[`PPW_BIT_ADDR_EXT_ON];
  assign large_page_ext    = feature_control_word[`PPW_BIT_LARGE_PAGE_EXT];
  assign ext_mode          = paging_on & addr_extension_on;

  // bits 9..11 never enter any mask or field, so software may use them
  assign ent_present = mem_rdata[`PPW_BIT_PRESENT];
  // page size comes from the entry alone; large_page_ext is not consulted
  assign ent_large   = mem_rdata[`PPW_BIT_LARGE_SELECT];
  assign ptr_rsvd    = |(mem_rdata & `PPW_RSVD_POINTER);
  assign dir_rsvd    = |(mem_rdata & (ent_large ? `PPW_RSVD_LARGE : `PPW_RSVD_TABLE));
  assign tbl_rsvd    = |(mem_rdata & `PPW_RSVD_TABLE);

  // flags are only ever or-ed in, so hardware never clears them
  assign need_upd = ~mem_rdata[`PPW_BIT_ACCESSED] | (wr_q & ~mem_rdata[`PPW_BIT_DIRTY]);
  always_comb begin
    upd_data = mem_rdata;
    upd_data[`PPW_BIT_ACCESSED] = 1'b1;
    if (wr_q) begin
      upd_data[`PPW_BIT_DIRTY] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // address formation, 64-bit entries so index is scaled by eight
  // ----------------------------------------------------------------
  assign ptr_addr   = {4'h0, translation_root_pointer[31:`PPW_ROOT_BASE_LSB],
                       req.lin[31:30], 3'h0};
  assign dir_addr   = {mem_rdata[35:12], lin_q[29:21], 3'h0};
  assign tbl_addr   = {mem_rdata[35:12], lin_q[20:12], 3'h0};
  assign small_phys = {mem_rdata[35:12], lin_q[11:0]};
  assign large_phys = {mem_rdata[35:21], lin_q[20:0]};

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  assign req_ready = (state == S_IDLE);
  assign rsp_valid = (state == S_DONE);
  assign rsp       = rsp_q;
  assign mem_req   = (state == S_PTR) || (state == S_DIR) || (state == S_TBL) || (state == S_UPD);
  assign mem_we    = (state == S_UPD);

  // ----------------------------------------------------------------
  // walk sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state     <= S_IDLE;
      lin_q     <= 32'h0000_0000;
      wr_q      <= 1'b0;
      large_q   <= 1'b0;
      ext_q     <= 1'b0;
      mem_addr  <= 36'h0_0000_0000;
      mem_wdata <= 64'h0000_0000_0000_0000;
      rsp_q     <= '0;
    end else if (ce) begin
      case (state)
        S_IDLE: begin
          if (req_valid) begin
            lin_q   <= req.lin;
            wr_q    <= req.write;
            large_q <= 1'b0;
            ext_q   <= ext_mode;
            if (ext_mode) begin
              mem_addr <= ptr_addr;
              state    <= S_PTR;
            end else begin
              // outside extended mode the address passes untranslated
              rsp_q <= '{phys: {4'h0, req.lin}, page_fault: 1'b0, prot_fault: 1'b0};
              state <= S_DONE;
            end
          end
        end
        S_PTR: begin
          if (mem_ack) begin
            if (!ent_present) begin
              rsp_q <= '{phys: '0, page_fault: 1'b1, prot_fault: 1'b0};
              state <= S_DONE;
            end else if (ptr_rsvd) begin
              rsp_q <= '{phys: '0, page_fault: 1'b0, prot_fault: 1'b1};
              state <= S_DONE;
            end else begin
              mem_addr <= dir_addr;
              state    <= S_DIR;
            end
          end
        end
        S_DIR: begin
          if (mem_ack) begin
            if (!ent_present || dir_rsvd) begin
              rsp_q <= '{phys: '0, page_fault: 1'b1, prot_fault: 1'b0};
              state <= S_DONE;
            end else if (ent_large) begin
              large_q    <= 1'b1;
              rsp_q      <= '{phys: large_phys, page_fault: 1'b0, prot_fault: 1'b0};
              mem_wdata  <= upd_data;
              // mem_addr still points at this entry for the flag write-back
              state      <= need_upd ? S_UPD : S_DONE;
            end else begin
              mem_addr <= tbl_addr;
              state    <= S_TBL;
            end
          end
        end
        S_TBL: begin
          if (mem_ack) begin
            if (!ent_present || tbl_rsvd) begin
              rsp_q <= '{phys: '0, page_fault: 1'b1, prot_fault: 1'b0};
              state <= S_DONE;
            end else begin
              rsp_q     <= '{phys: small_phys, page_fault: 1'b0, prot_fault: 1'b0};
              mem_wdata <= upd_data;
              state     <= need_upd ? S_UPD : S_DONE;
            end
          end
        end
        S_UPD: begin
          if (mem_ack) begin
            state <= S_DONE;
          end
        end
        S_DONE: begin
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // fault address capture
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_linear <= 32'h0000_0000;
    end else if (ce && rsp_valid && (rsp_q.page_fault || rsp_q.prot_fault)) begin
      fault_linear <= lin_q;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // changes take effect at the next walk; a walk in flight keeps its mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      system_control_0         <= `PPW_RST_SYS_CONTROL_0;
      feature_control_word     <= `PPW_RST_FEATURE_CONTROL;
      translation_root_pointer <= `PPW_RST_ROOT_POINTER;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        `PPW_OFF_SYS_CONTROL_0:   system_control_0         <= reg_wdata;
        `PPW_OFF_FEATURE_CONTROL: feature_control_word     <= reg_wdata;
        `PPW_OFF_ROOT_POINTER:    translation_root_pointer <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------
  always_comb begin
    id_features = 32'h0000_0000;
    id_features[`PPW_BIT_ID_ADDR_EXT] = 1'b1;
  end
  assign status_word = {25'h000_0000, large_page_ext, ext_q, large_q,
                        rsp_q.prot_fault, rsp_q.page_fault, ext_mode, ~req_ready};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `PPW_OFF_SYS_CONTROL_0:   reg_rdata <= system_control_0;
          `PPW_OFF_FEATURE_CONTROL: reg_rdata <= feature_control_word;
          `PPW_OFF_ROOT_POINTER:    reg_rdata <= translation_root_pointer;
          `PPW_OFF_ID_FEATURES:     reg_rdata <= id_features;
          `PPW_OFF_STATUS:          reg_rdata <= status_word;
          `PPW_OFF_PHYS_WIDTH:      reg_rdata <= 32'(`PPW_PHYS_WIDTH);
          `PPW_OFF_FAULT_LINEAR:    reg_rdata <= fault_linear;
          `PPW_OFF_LAST_FRAME:      reg_rdata <= {8'h00, rsp_q.phys[35:12]};
          default:                  reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !ce);

  logic accept;
  assign accept = req_valid && req_ready && ce;

  property p_bypass;
    accept && !ext_mode |=> rsp_valid && rsp.phys == {4'h0, $past(req.lin)} && !rsp.page_fault;
  endproperty
  a_bypass: assert property (p_bypass) else $error("untranslated answer wrong");

  property p_ptr_addr;
    accept && ext_mode |=> mem_req && !mem_we
      && mem_addr == {4'h0, translation_root_pointer[31:5], $past(req.lin[31:30]), 3'h0};
  endproperty
  a_ptr_addr: assert property (p_ptr_addr) else $error("pointer entry address wrong");

  property p_dir_addr;
    state == S_PTR && mem_ack && ent_present && !ptr_rsvd
      |=> state == S_DIR && mem_addr == {$past(mem_rdata[35:12]), lin_q[29:21], 3'h0};
  endproperty
  a_dir_addr: assert property (p_dir_addr) else $error("directory entry address wrong");

  property p_tbl_addr;
    state == S_DIR && mem_ack && ent_present && !dir_rsvd && !ent_large
      |=> state == S_TBL && mem_addr == {$past(mem_rdata[35:12]), lin_q[20:12], 3'h0};
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("table entry address wrong");

  property p_prot_fault;
    state == S_PTR && mem_ack && ent_present && ptr_rsvd
      |=> rsp_valid && rsp.prot_fault && !rsp.page_fault;
  endproperty
  a_prot_fault: assert property (p_prot_fault) else $error("pointer reserved bits missed");

  property p_not_present;
    (state == S_DIR || state == S_TBL) && mem_ack && !ent_present
      |=> rsp_valid && rsp.page_fault && !rsp.prot_fault;
  endproperty
  a_not_present: assert property (p_not_present) else $error("absent entry not faulted");

  property p_rsvd_fault;
    state == S_TBL && mem_ack && ent_present && tbl_rsvd |=> rsp_valid && rsp.page_fault;
  endproperty
  a_rsvd_fault: assert property (p_rsvd_fault) else $error("table reserved bits missed");

  property p_offset;
    rsp_valid && ext_q && !rsp.page_fault && !rsp.prot_fault
      |-> (large_q ? rsp.phys[20:0] == lin_q[20:0] : rsp.phys[11:0] == lin_q[11:0]);
  endproperty
  a_offset: assert property (p_offset) else $error("page offset not carried");

  // data is launched on entry to the write-back, so stability is only asked from its second cycle on
  property p_dirty;
    mem_we |-> mem_wdata[`PPW_BIT_ACCESSED] && (mem_wdata[`PPW_BIT_DIRTY] || !wr_q)
      && ($stable(mem_wdata) || !$past(mem_we));
  endproperty
  a_dirty: assert property (p_dirty) else $error("flag write-back wrong");

  property p_id_flag;
    reg_rd && reg_addr == `PPW_OFF_ID_FEATURES |=> reg_rdata[`PPW_BIT_ID_ADDR_EXT];
  endproperty
  a_id_flag: assert property (p_id_flag) else $error("feature flag not reported");

  property p_ptr_absent;
    state == S_PTR && mem_ack && !ent_present |=> rsp_valid && rsp.page_fault && !rsp.prot_fault;
  endproperty
  a_ptr_absent: assert property (p_ptr_absent) else $error("absent pointer entry not faulted");

  property p_large_base;
    state == S_DIR && mem_ack && ent_present && !dir_rsvd && ent_large
      |=> rsp.phys[35:21] == $past(mem_rdata[35:21]);
  endproperty
  a_large_base: assert property (p_large_base) else $error("large page base wrong");

  // frozen cycles must not advance the walk nor move the memory address
  property p_freeze;
    disable iff (rst) !ce && !rst |=> $stable(state) && $stable(mem_addr);
  endproperty
  a_freeze: assert property (p_freeze) else $error("walk moved while frozen");

  c_large: cover property (rsp_valid && large_q && !rsp.page_fault);
  c_small: cover property (rsp_valid && ext_q && !large_q && !rsp.page_fault && !rsp.prot_fault);
  c_prot:  cover property (rsp_valid && rsp.prot_fault);
  c_write: cover property (mem_we && mem_ack && wr_q);

endmodule

// [include/ppw_page_walker_cfg.svh]
/*
  Constants of the extended-address page walker: register offsets, field positions,
  reserved-bit masks and reset values. Assumes inclusion by bare name from include/.
*/
`ifndef PPW_PAGE_WALKER_CFG_SVH
`define PPW_PAGE_WALKER_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define PPW_OFF_SYS_CONTROL_0   8'h00
`define PPW_OFF_FEATURE_CONTROL 8'h04
`define PPW_OFF_ROOT_POINTER    8'h08
`define PPW_OFF_ID_FEATURES     8'h0c
`define PPW_OFF_STATUS          8'h10
`define PPW_OFF_PHYS_WIDTH      8'h14
`define PPW_OFF_FAULT_LINEAR    8'h18
`define PPW_OFF_LAST_FRAME      8'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PPW_BIT_PAGING_ON       31
`define PPW_BIT_ADDR_EXT_ON     5
`define PPW_BIT_LARGE_PAGE_EXT  4
`define PPW_BIT_ID_ADDR_EXT     6
`define PPW_BIT_PRESENT         0
`define PPW_BIT_ACCESSED        5
`define PPW_BIT_DIRTY           6
`define PPW_BIT_LARGE_SELECT    7
`define PPW_ROOT_BASE_LSB       5

// ----------------------------------------------------------------
// widths and reserved-bit masks of 64-bit entries
// ----------------------------------------------------------------
`define PPW_PHYS_WIDTH          36
`define PPW_RSVD_POINTER        64'hffff_fff0_0000_01e6
`define PPW_RSVD_TABLE          64'hffff_fff0_0000_0000
`define PPW_RSVD_LARGE          64'hffff_fff0_001f_e000

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PPW_RST_SYS_CONTROL_0   32'h0000_0000
`define PPW_RST_FEATURE_CONTROL 32'h0000_0000
`define PPW_RST_ROOT_POINTER    32'h0000_0000

`endif

// [include/ppw_pkg.sv]
/*
  Types of the extended-address page walker: walk states and the request and
  answer carriers. Assumes ppw_page_walker_cfg.svh is reachable on the include path.
*/
`include "ppw_page_walker_cfg.svh"

package ppw_pkg;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_PTR  = 3'h1,
    S_DIR  = 3'h3,
    S_TBL  = 3'h2,
    S_UPD  = 3'h6,
    S_DONE = 3'h7
  } ppw_state_t;

  typedef struct packed {
    logic [31:0] lin;
    logic        write;
  } ppw_req_t;

  typedef struct packed {
    logic [`PPW_PHYS_WIDTH-1:0] phys;
    logic                       page_fault;
    logic                       prot_fault;
  } ppw_rsp_t;

endpackage

// [tb/ppw_mem_model.sv]
/*
  Behavioural system memory holding the 64-bit paging entries, answering mem_req
  after a programmable number of wait cycles and taking flag write-backs.
  Assumes one clock, and a requester that holds address and data until mem_ack.
*/
`timescale 1ns/1ps

module ppw_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [35:0] mem_addr,
  input  wire logic [63:0] mem_wdata,
  output logic             mem_ack,
  output logic [63:0]      mem_rdata
);
  logic [63:0] mem [logic [32:0]];
  logic [63:0] last = 64'h0;
  int          wait_cnt = 0;
  int          delay = 0;
  int          n_acc = 0;
  int          n_writes = 0;

  function automatic logic [63:0] peek(input logic [35:0] a);
    return mem.exists(a[35:3]) ? mem[a[35:3]] : 64'h0;
  endfunction

  function automatic void poke(input logic [35:0] a, input logic [63:0] d);
    mem[a[35:3]] = d;
  endfunction

  assign mem_ack = mem_req && (wait_cnt >= delay);
  // idle data bus shows the inverse of the last word driven, so after a write-back it repeats the last word read
  always @* mem_rdata = (mem_ack && !mem_we) ? peek(mem_addr) : ~last;

  always @(posedge ref_clk) begin
    if (mem_ack) begin
      wait_cnt <= 0;
      last     <= mem_rdata;
      n_acc++;
      if (mem_we) begin
        mem[mem_addr[35:3]] = mem_wdata;
        n_writes++;
      end
    end else if (mem_req) begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// [tb/ppw_page_walker_tb.sv]
/*
  Self-checking bench of the page walker: register access, bypass translation,
  small and large page walks, flag write-back and faults.
  Assumes ppw_mem_model as system memory and the cfg header on the include path.
*/
`timescale 1ns/1ps
`include "ppw_page_walker_cfg.svh"

module ppw_page_walker_tb;
  import ppw_pkg::*;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

  localparam logic [31:0] ROOT = 32'h0000_2020;
  localparam ppw_rsp_t    PAGE_FLT = '{36'h0, 1'b1, 1'b0};
  localparam ppw_rsp_t    PROT_FLT = '{36'h0, 1'b0, 1'b1};
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  ppw_req_t    req = '0;
  logic        req_valid = 1'b0;
  logic        req_ready, rsp_valid, mem_req, mem_we, mem_ack;
  ppw_rsp_t    rsp;
  logic [35:0] mem_addr;
  logic [63:0] mem_wdata, mem_rdata;
  int          n_fail = 0;
  int          check_count = 0;

  always #25 ref_clk = ~ref_clk;

  ppw_page_walker i_ppw_page_walker (.ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  ppw_mem_model i_ppw_mem_model (.ref_clk(ref_clk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ----------------------------------------------------------------
  // bus and translation tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  // waits are bounded; a hang counts as a mismatch and ends the run
  task automatic walk(input logic [31:0] lin, input logic wr, input logic [63:0] pe, de, te,
                      input ppw_rsp_t e);
    int i;
    i_ppw_mem_model.poke({4'h0, ROOT[31:5], lin[31:30], 3'h0}, pe);
    i_ppw_mem_model.poke({pe[35:12], lin[29:21], 3'h0}, de);
    i_ppw_mem_model.poke({de[35:12], lin[20:12], 3'h0}, te);
    @(posedge ref_clk);
    req <= '{lin, wr};
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    for (i = 0; i < 60; i++) begin
      #1;
      if (rsp_valid === 1'b1) break;
      @(posedge ref_clk);
    end
    if (i == 60) begin
      n_fail++;
      tally_and_finish();
    end else begin
      `CHK(rsp, e)
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  localparam logic [31:0] LS = 32'hc4a5_6789;
  localparam logic [63:0] PE = 64'h0000_0009_1234_5e01;
  localparam logic [63:0] DE = 64'h0000_0003_3333_3e21;
  localparam logic [63:0] TE = 64'h0000_0008_abcd_ee61;
  localparam logic [35:0] TA = {DE[35:12], LS[20:12], 3'h0};

  task automatic t_regs();
    reg_check(`PPW_OFF_ROOT_POINTER, 32'h0);
    reg_check(`PPW_OFF_ID_FEATURES, 32'h0000_0040);
    reg_check(`PPW_OFF_PHYS_WIDTH, 32'h0000_0024);
    reg_write(`PPW_OFF_ROOT_POINTER, ROOT);
    reg_write(`PPW_OFF_ID_FEATURES, 32'h0);
    reg_check(`PPW_OFF_ROOT_POINTER, ROOT);
    reg_check(`PPW_OFF_ID_FEATURES, 32'h0000_0040);
    reg_check(8'h20, 32'h0);
  endtask

  task automatic t_bypass();
    int n0;
    n0 = i_ppw_mem_model.n_acc;
    reg_write(`PPW_OFF_SYS_CONTROL_0, 32'h8000_0000);
    walk(32'hdead_beef, 1'b0, PE, DE, TE, '{36'h0_dead_beef, 1'b0, 1'b0});
    reg_write(`PPW_OFF_SYS_CONTROL_0, 32'h0);
    reg_write(`PPW_OFF_FEATURE_CONTROL, 32'h0000_0020);
    walk(LS, 1'b1, PE, DE, TE, '{{4'h0, LS}, 1'b0, 1'b0});
    `CHK(i_ppw_mem_model.n_acc, n0)
  endtask

  task automatic t_small();
    int w0;
    reg_write(`PPW_OFF_SYS_CONTROL_0, 32'h8000_0000);
    w0 = i_ppw_mem_model.n_writes;
    walk(LS, 1'b0, PE, DE, TE, '{{TE[35:12], LS[11:0]}, 1'b0, 1'b0});
    reg_write(`PPW_OFF_FEATURE_CONTROL, 32'h0000_0030);
    i_ppw_mem_model.delay = 2;
    walk(LS, 1'b1, PE, DE, TE, '{{TE[35:12], LS[11:0]}, 1'b0, 1'b0});
    i_ppw_mem_model.delay = 0;
    `CHK(i_ppw_mem_model.n_writes, w0)
  endtask

  task automatic t_flags();
    logic [63:0] te0;
    int w0;
    te0 = TE & ~64'h60;
    walk(LS, 1'b0, PE, DE, te0, '{{TE[35:12], LS[11:0]}, 1'b0, 1'b0});
    `CHK(i_ppw_mem_model.peek(TA), te0 | 64'h20)
    walk(LS, 1'b1, PE, DE, te0 | 64'h20, '{{TE[35:12], LS[11:0]}, 1'b0, 1'b0});
    `CHK(i_ppw_mem_model.peek(TA), te0 | 64'h60)
    `CHK(i_ppw_mem_model.peek({PE[35:12], LS[29:21], 3'h0}), DE)
    w0 = i_ppw_mem_model.n_writes;
    walk(LS, 1'b0, PE, DE, TE, '{{TE[35:12], LS[11:0]}, 1'b0, 1'b0});
    `CHK(i_ppw_mem_model.n_writes, w0)
  endtask

  task automatic t_large();
    logic [63:0] dl;
    logic [31:0] lin;
    dl = 64'h0000_0005_4020_0e81;
    lin = 32'h4123_4567;
    walk(lin, 1'b1, PE, dl, TE, '{{dl[35:21], lin[20:0]}, 1'b0, 1'b0});
    `CHK(i_ppw_mem_model.peek({PE[35:12], lin[29:21], 3'h0}), dl | 64'h60)
    reg_write(`PPW_OFF_FEATURE_CONTROL, 32'h0000_0020);
    walk(lin, 1'b0, PE, dl | 64'h60, TE, '{{dl[35:21], lin[20:0]}, 1'b0, 1'b0});
    reg_check(`PPW_OFF_STATUS, 32'h0000_0032);
  endtask

  task automatic t_faults();
    walk(LS, 1'b0, 64'h0, DE, TE, PAGE_FLT);
    walk(LS, 1'b0, 64'hffff_ffff_ffff_fffe, DE, TE, PAGE_FLT);
    walk(LS, 1'b0, PE | 64'h2, DE, TE, PROT_FLT);
    walk(LS, 1'b0, PE | 64'h1_0000_0000_0000, DE, TE, PROT_FLT);
    walk(LS, 1'b0, PE, DE & ~64'h1, TE, PAGE_FLT);
    walk(LS, 1'b0, PE, DE | 64'h100_0000_0000, TE, PAGE_FLT);
    walk(LS, 1'b0, PE, 64'h0000_0005_4020_2ee1, TE, PAGE_FLT);
    walk(LS, 1'b0, PE, DE, TE | 64'h10_0000_0000, PAGE_FLT);
    walk(LS, 1'b0, PE, DE, TE & ~64'h1, PAGE_FLT);
    walk(LS, 1'b0, PE, DE, TE, '{{TE[35:12], LS[11:0]}, 1'b0, 1'b0});
    reg_check(`PPW_OFF_FAULT_LINEAR, LS);
    reg_check(`PPW_OFF_LAST_FRAME, {8'h00, TE[35:12]});
  endtask

  // with the enable low neither a register write nor a request may be taken
  task automatic t_freeze();
    int n0;
    n0 = i_ppw_mem_model.n_acc;
    @(posedge ref_clk);
    ce <= 1'b0;
    req <= '{LS, 1'b0};
    req_valid <= 1'b1;
    reg_write(`PPW_OFF_ROOT_POINTER, 32'h0000_4040);
    req_valid <= 1'b0;
    @(posedge ref_clk);
    ce <= 1'b1;
    reg_check(`PPW_OFF_ROOT_POINTER, ROOT);
    `CHK(i_ppw_mem_model.n_acc, n0)
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_bypass();
    t_small();
    t_flags();
    t_large();
    t_faults();
    t_freeze();
    tally_and_finish();
  end
endmodule
